/* File: bench/kir_keypad_model.sv */
// Model of the switches wired to the keypad pins.
// Assumes the unit's pad controls give the level of a released pin.
`timescale 1ns/1ns
`default_nettype none
module kir_keypad_model
    import kir_pkg::*;
#(
    parameter int NUM_PINS = KIR_DEF_PINS
) (
    input wire logic clk_in,
    input wire logic [NUM_PINS-1:0] press_in,
    input wire logic [NUM_PINS-1:0] act_level_in,
    input wire logic [NUM_PINS-1:0] pullup_en_in,
    input wire logic [NUM_PINS-1:0] pulldown_en_in,
    output logic [NUM_PINS-1:0] pin_out
);
    // A floating pin changes every cycle so no settled value hides a fault
    logic [NUM_PINS-1:0] float_pat = {NUM_PINS{1'b0}};

    // Free-running pattern for unpulled, released pins
    always_ff @(posedge clk_in) begin
        float_pat <= ~float_pat;
    end

    // Pressed key drives its level, else the pad pull decides
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (press_in[i]) begin
                pin_out[i] = act_level_in[i];
            end else if (pullup_en_in[i]) begin
                pin_out[i] = 1'b1;
            end else if (pulldown_en_in[i]) begin
                pin_out[i] = 1'b0;
            end else begin
                pin_out[i] = float_pat[i];
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the keypad interrupt unit.
// Assumes the register map and status layout of kir_pkg.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import kir_pkg::*;
    localparam int NP = 6; // Pins under test
    logic clk = 1'b0; // Bus clock, 50 ns
    logic rst = 1'b1; // Synchronous reset
    kir_bus_req_t bus = '{addr: 2'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    logic vf = 1'b0; // Vector fetch acknowledge
    logic brk = 1'b0; // Debug break
    logic bce = 1'b0; // Break clear enable
    logic en = 1'b1; // Clock enable, dropped once to test the freeze
    logic [NP-1:0] press = 6'h00; // Keys held down
    logic [NP-1:0] act = 6'h00; // Level a held key drives
    logic [NP-1:0] pins, pu, pd, fi;
    logic [KIR_DATA_W-1:0] rdata;
    logic irq;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;

    always #25 clk = ~clk;

    kir_keypad_irq #(.NUM_PINS(NP)) i_dut (.clk_in(clk), .rst_in(rst), .clk_en_in(en),
        .bus_in(bus), .rdata_out(rdata), .pin_in(pins), .vector_fetch_in(vf),
        .break_active_in(brk), .break_clear_enable_in(bce), .irq_out(irq),
        .pullup_en_out(pu), .pulldown_en_out(pd), .force_input_out(fi));

    kir_keypad_model #(.NUM_PINS(NP)) i_keys (.clk_in(clk), .press_in(press),
        .act_level_in(act), .pullup_en_in(pu), .pulldown_en_in(pd), .pin_out(pins));

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        @(negedge clk);
        chk("rdata", rdata, exp);
        // Hand back on a rising edge so callers drive right after it
        @(posedge clk);
    endtask

    task automatic key(input int i, input logic on);
        @(posedge clk);
        press[i] <= on;
    endtask

    // Reset values, reserved bits, unmapped slot, pad controls
    task automatic t_regs();
        rd(KIR_REG_STATUS, 8'h00);
        rd(KIR_REG_ENABLE, 8'h00);
        rd(KIR_REG_POLARITY, 8'h00);
        rd(2'h3, 8'h00);
        wr(KIR_REG_ENABLE, 8'h7F); // Reserved bit 6 written 1
        rd(KIR_REG_ENABLE, 8'h3F);
        chk("force_input", {2'h0, fi}, 8'h3F);
        chk("pullup", {2'h0, pu}, 8'h3F);
        wr(KIR_REG_POLARITY, 8'h3F);
        rd(KIR_REG_POLARITY, 8'h3F);
        chk("pulldown", {2'h0, pd}, 8'h3F);
        chk("pullup", {2'h0, pu}, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        wr(KIR_REG_POLARITY, 8'h00);
        wr(KIR_REG_ENABLE, 8'h00);
        $display("TB: test regs done");
    endtask

    // Edge mode: latch, mask, vector fetch, blocked edge, soft ack
    task automatic t_edge();
        wr(KIR_REG_STATUS, 8'h02); // Init order mask, enable, ack
        wr(KIR_REG_ENABLE, 8'h03);
        wt(4); // Pad pull and synchroniser settle first
        wr(KIR_REG_STATUS, 8'h06);
        wr(KIR_REG_STATUS, 8'h00);
        rd(KIR_REG_STATUS, 8'h00); // False request discarded
        key(0, 1'b1);
        wt(6);
        chk("irq", {7'h0, irq}, 8'h01);
        rd(KIR_REG_STATUS, 8'h08);
        wr(KIR_REG_STATUS, 8'h02);
        rd(KIR_REG_STATUS, 8'h0A);
        chk("irq", {7'h0, irq}, 8'h00);
        wr(KIR_REG_STATUS, 8'h00);
        @(posedge clk);
        vf <= 1'b1;
        @(posedge clk);
        vf <= 1'b0;
        rd(KIR_REG_STATUS, 8'h00); // Key still held
        key(1, 1'b1);
        wt(6);
        rd(KIR_REG_STATUS, 8'h00);
        press <= 6'h00;
        wt(6);
        key(1, 1'b1);
        wt(6);
        rd(KIR_REG_STATUS, 8'h08);
        wr(KIR_REG_STATUS, 8'h04);
        rd(KIR_REG_STATUS, 8'h00);
        key(1, 1'b0);
        key(2, 1'b1);
        wt(6);
        rd(KIR_REG_STATUS, 8'h00); // Disabled pin
        key(2, 1'b0);
        $display("TB: test edge done");
    endtask

    // Rising polarity on one pin
    task automatic t_rise();
        wr(KIR_REG_POLARITY, 8'h04);
        wr(KIR_REG_ENABLE, 8'h04);
        wt(4); // Pulldown settles before the acknowledge
        wr(KIR_REG_STATUS, 8'h04);
        rd(KIR_REG_STATUS, 8'h00);
        act <= 6'h04;
        key(2, 1'b1);
        wt(6);
        rd(KIR_REG_STATUS, 8'h08);
        key(2, 1'b0);
        wr(KIR_REG_STATUS, 8'h04);
        rd(KIR_REG_STATUS, 8'h00);
        act <= 6'h00;
        $display("TB: test rise done");
    endtask

    // Level mode: both orders of release and ack, then reset while held
    task automatic t_level();
        wr(KIR_REG_POLARITY, 8'h00);
        wr(KIR_REG_ENABLE, 8'h01);
        wt(4); // Level pin acknowledged only after the pull settles
        wr(KIR_REG_STATUS, 8'h05);
        rd(KIR_REG_STATUS, 8'h01);
        key(0, 1'b1);
        wt(6);
        rd(KIR_REG_STATUS, 8'h09);
        wr(KIR_REG_STATUS, 8'h05);
        wt(3);
        rd(KIR_REG_STATUS, 8'h09);
        key(0, 1'b0);
        wt(6);
        rd(KIR_REG_STATUS, 8'h01);
        key(0, 1'b1);
        wt(6);
        key(0, 1'b0);
        wt(6);
        rd(KIR_REG_STATUS, 8'h09);
        wr(KIR_REG_STATUS, 8'h05);
        rd(KIR_REG_STATUS, 8'h01);
        key(0, 1'b1);
        wt(6);
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        @(negedge clk);
        chk("irq", {7'h0, irq}, 8'h00);
        rd(KIR_REG_STATUS, 8'h00);
        key(0, 1'b0);
        $display("TB: test level done");
    endtask

    // Break protects the flag unless clears are enabled
    task automatic t_break();
        wr(KIR_REG_ENABLE, 8'h01);
        wt(4); // Pullup settles before the acknowledge
        wr(KIR_REG_STATUS, 8'h04);
        rd(KIR_REG_STATUS, 8'h00);
        key(0, 1'b1);
        wt(6);
        brk <= 1'b1;
        wr(KIR_REG_STATUS, 8'h04);
        rd(KIR_REG_STATUS, 8'h08);
        bce <= 1'b1;
        wr(KIR_REG_STATUS, 8'h04);
        rd(KIR_REG_STATUS, 8'h00);
        brk <= 1'b0;
        bce <= 1'b0;
        key(0, 1'b0);
        // A write while the clock enable is low must not land
        en <= 1'b0;
        wr(KIR_REG_ENABLE, 8'h02);
        en <= 1'b1;
        rd(KIR_REG_ENABLE, 8'h01);
        $display("TB: test break done");
    endtask

    task automatic stop_test();
        $display("TB: checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        wt(16);
        rst <= 1'b0;
        t_regs();
        t_edge();
        t_rise();
        t_level();
        t_break();
        stop_test();
    end
endmodule
`default_nettype wire

/* File: design/kir_keypad_irq.sv */
// Keypad interrupt unit: per-pin enable and polarity, one shared latch,
// one maskable request, pad pull and direction override controls.
// Assumes a single-cycle register bus on clk_in and a vector fetch
// pulse from the interrupt priority logic on the same clock.
// Operation
// - each pin has its own enable bit
// - enabled pin gets pullup or pulldown by polarity
// - asserted enabled input sets shared latch
// - edge ignored while another input asserted
// - level mode keeps request while input asserted
// - level mode clears after release and acknowledge
// - vector fetch acknowledge clears the latch
// - acknowledge bit write clears, reads zero
// - edge after acknowledge latches fresh request
// - reset clears request and trigger sensitivity
// - edge mode acknowledge clears latch at once
// - pending flag readable regardless of mask
// - mask bit gates interrupt request output
// - enabled pin forced to input direction
// - unit stays active in low-power modes
// - break protects status unless clear enabled
// - sensitivity bit picks level-and-edge or edge
// - reserved enable bit reads zero
// - enable bit lets pin latch requests
// - polarity bit picks high/rising or low/falling
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module kir_keypad_irq
    import kir_pkg::*;
#(
    parameter int NUM_PINS = KIR_DEF_PINS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire kir_bus_req_t bus_in,
    output logic [KIR_DATA_W-1:0] rdata_out,
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic vector_fetch_in,
    input wire logic break_active_in,
    input wire logic break_clear_enable_in,
    output logic irq_out,
    output logic [NUM_PINS-1:0] pullup_en_out,
    output logic [NUM_PINS-1:0] pulldown_en_out,
    output logic [NUM_PINS-1:0] force_input_out
);

    // One register holds the enables and leaves one reserved bit
    if (NUM_PINS < 1 || NUM_PINS > KIR_MAX_PINS) begin : g_bad_pins
        $error("NUM_PINS must lie between 1 and 7");
    end

    // Software-visible control state
    logic [NUM_PINS-1:0] pin_irq_enable;
    logic [NUM_PINS-1:0] pin_polarity_select;
    logic trigger_sensitivity;
    logic request_mask;

    // Latch state and detection helpers
    kir_state_t state;
    kir_state_t next_state;
    logic [NUM_PINS-1:0] sample;
    logic [NUM_PINS-1:0] asserted;
    logic any_asserted;
    logic any_prev;
    logic rise;
    logic wr_status;
    logic sw_ack;
    logic ack;
    logic pending_flag;
    logic level_hold;

    // Synchronised pin samples
    kir_pin_sync #(
        .NUM_PINS(NUM_PINS)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .pin_in(pin_in),
        .sample_out(sample)
    );

    // Per-pin assertion: polarity picks the active level, enable gates it
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        assign asserted[i] = pin_irq_enable[i]
            & (pin_polarity_select[i] ? sample[i] : ~sample[i]);
    end

    // The OR of all pins is what the shared latch watches
    assign any_asserted = |asserted;

    // History of the combined level, compared sample to sample
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            any_prev <= 1'h0;
        end else if (clk_en_in) begin
            any_prev <= any_asserted;
        end
    end

    // Only a rise of the combined level counts, so an edge on one pin
    // is lost while another pin is already asserted
    assign rise = any_asserted & ~any_prev;
    // Limitation: a pin enabled while it floats can read as a rise for a
    // few cycles, since the pad pull lags the enable by one flop and the
    // synchroniser adds two more; software should acknowledge after that
    // window has passed, or the stale edge latches a fresh request.

    // Level term only in edge-and-level mode
    assign level_hold = trigger_sensitivity & any_asserted;

    // Software acknowledge, suppressed in break unless clearing allowed
    assign wr_status = bus_in.wr && (bus_in.addr == KIR_REG_STATUS);
    assign sw_ack = wr_status && bus_in.wdata[KIR_BIT_ACK]
        && (!break_active_in || break_clear_enable_in);

    // Either acknowledge source clears
    assign ack = vector_fetch_in | sw_ack;

    // Latch next state; a new edge wins over a same-cycle acknowledge
    always_comb begin
        next_state = state;
        case (state)
            KIR_ST_IDLE: begin
                // Level mode re-arms straight away while still asserted
                if (rise || level_hold) begin
                    next_state = KIR_ST_PEND;
                end
            end
            KIR_ST_PEND: begin
                if (rise) begin
                    next_state = KIR_ST_PEND;
                end else if (ack && level_hold) begin
                    // Acknowledged but a pin is still held active
                    next_state = KIR_ST_HELD;
                end else if (ack) begin
                    next_state = KIR_ST_IDLE;
                end
            end
            KIR_ST_HELD: begin
                // Acknowledge already seen; release finishes the clear
                if (rise) begin
                    next_state = KIR_ST_PEND;
                end else if (!level_hold) begin
                    next_state = KIR_ST_IDLE;
                end
            end
            default: begin
                next_state = KIR_ST_IDLE;
            end
        endcase
    end

    // Latch register; keeps running in low-power modes since nothing
    // here depends on the processor clock being gated
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= KIR_ST_IDLE;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    // Flag is the latch itself, independent of the mask
    assign pending_flag = (state != KIR_ST_IDLE);

    // Request to the priority logic, also the wake-up source
    assign irq_out = pending_flag & ~request_mask;

    // Status/control writes: mask and trigger sensitivity
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trigger_sensitivity <= KIR_RST_MODE;
            request_mask <= KIR_RST_MASK;
        end else if (clk_en_in && wr_status) begin
            trigger_sensitivity <= bus_in.wdata[KIR_BIT_MODE];
            request_mask <= bus_in.wdata[KIR_BIT_MASK];
        end
    end

    // Per-pin enable and polarity registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_irq_enable <= '0;
            pin_polarity_select <= '0;
        end else if (clk_en_in && bus_in.wr) begin
            if (bus_in.addr == KIR_REG_ENABLE) begin
                pin_irq_enable <= bus_in.wdata[NUM_PINS-1:0];
            end
            if (bus_in.addr == KIR_REG_POLARITY) begin
                pin_polarity_select <= bus_in.wdata[NUM_PINS-1:0];
            end
        end
    end

    // Pad controls from flops: pull toward the idle level of each
    // enabled pin, and force it to input over the direction bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pullup_en_out <= '0;
            pulldown_en_out <= '0;
            force_input_out <= '0;
        end else if (clk_en_in) begin
            pullup_en_out <= pin_irq_enable & ~pin_polarity_select;
            pulldown_en_out <= pin_irq_enable & pin_polarity_select;
            force_input_out <= pin_irq_enable;
        end
    end

    // Read data one cycle after the strobe; unmapped index reads zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= KIR_RST_ZERO;
        end else if (clk_en_in) begin
            rdata_out <= KIR_RST_ZERO;
            if (bus_in.rd) begin
                case (bus_in.addr)
                    KIR_REG_STATUS: begin
                        // Acknowledge bit is write-only and reads zero
                        rdata_out[KIR_BIT_FLAG] <= pending_flag;
                        rdata_out[KIR_BIT_MASK] <= request_mask;
                        rdata_out[KIR_BIT_MODE] <= trigger_sensitivity;
                    end
                    KIR_REG_ENABLE: begin
                        // Reserved bit above the enables stays zero
                        rdata_out[NUM_PINS-1:0] <= pin_irq_enable;
                    end
                    KIR_REG_POLARITY: begin
                        rdata_out[NUM_PINS-1:0] <= pin_polarity_select;
                    end
                    default: begin
                        rdata_out <= KIR_RST_ZERO;
                    end
                endcase
            end
        end
    end

    // Checks run on the bus clock and, but for a_reset_clears, sleep during reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Pads follow enable and polarity one cycle later
    a_pull_polarity: assert property (
        clk_en_in |=> (pullup_en_out == $past(pin_irq_enable & ~pin_polarity_select))
            && (pulldown_en_out == $past(pin_irq_enable & pin_polarity_select)))
        else $error("pull control does not match enable and polarity");

    // A rise of the combined level always leaves the latch pending
    a_edge_sets_flag: assert property (
        clk_en_in && rise |=> pending_flag)
        else $error("edge did not set the latch");

    // Edge mode, already asserted, idle latch stays idle
    a_edge_blocked: assert property (
        clk_en_in && state == KIR_ST_IDLE && !trigger_sensitivity && any_prev
            |=> state == KIR_ST_IDLE)
        else $error("latch set while a pin was already asserted");

    // Level mode holds the flag while any enabled pin is asserted
    a_level_holds: assert property (
        clk_en_in && trigger_sensitivity && any_asserted && pending_flag
            |=> pending_flag)
        else $error("level request dropped while pin asserted");

    // Edge mode vector fetch empties the latch at once
    a_ack_clears_edge: assert property (
        clk_en_in && !trigger_sensitivity && vector_fetch_in && !rise
            |=> state == KIR_ST_IDLE)
        else $error("acknowledge did not clear the latch");

    // Acknowledge bit never reads back as one
    a_ack_reads_zero: assert property (
        clk_en_in && bus_in.rd && bus_in.addr == KIR_REG_STATUS
            |=> !rdata_out[KIR_BIT_ACK])
        else $error("acknowledge bit read as one");

    // Flag read shows the latch even when masked
    a_flag_readback: assert property (
        clk_en_in && bus_in.rd && bus_in.addr == KIR_REG_STATUS
            |=> rdata_out[KIR_BIT_FLAG] == $past(pending_flag))
        else $error("pending flag read wrong");

    // Masked unit never requests
    a_mask_gates_irq: assert property (
        request_mask |-> !irq_out)
        else $error("request raised while masked");

    // Protected break keeps a pending latch through a software ack
    a_break_protect: assert property (
        clk_en_in && break_active_in && !break_clear_enable_in && wr_status
            && !vector_fetch_in && state == KIR_ST_PEND |=> pending_flag)
        else $error("status cleared during protected break");

    // Reset empties the latch and returns edge-only mode
    a_reset_clears: assert property (disable iff (1'h0)
        rst_in |=> !pending_flag && !trigger_sensitivity)
        else $error("reset left request or mode set");

    // Level mode acknowledge with a pin still active parks the latch
    a_level_ack_held: assert property (
        clk_en_in && state == KIR_ST_PEND && ack && level_hold && !rise
            |=> state == KIR_ST_HELD)
        else $error("level acknowledge did not wait for release");

    // Held latch clears once every enabled pin is released
    a_held_release: assert property (
        clk_en_in && state == KIR_ST_HELD && !level_hold && !rise
            |=> state == KIR_ST_IDLE)
        else $error("held request stayed after release");

    // Software acknowledge in edge mode empties the latch at once
    a_sw_ack_clears: assert property (
        clk_en_in && !trigger_sensitivity && sw_ack && !rise
            |=> state == KIR_ST_IDLE)
        else $error("software acknowledge did not clear the latch");

    // Direction override follows the enables one cycle later
    a_force_input: assert property (
        clk_en_in |=> force_input_out == $past(pin_irq_enable))
        else $error("direction override does not follow enable");

    // With every pin disabled an idle latch cannot be set
    a_idle_disabled: assert property (
        clk_en_in && pin_irq_enable == '0 && state == KIR_ST_IDLE
            |=> state == KIR_ST_IDLE)
        else $error("latch set with no pin enabled");

    // Unmasked latch always reaches the request line
    a_irq_follows: assert property (
        !request_mask && pending_flag |-> irq_out)
        else $error("unmasked request not raised");

    // Bits above the enables read back as zero
    a_reserved_zero: assert property (
        clk_en_in && bus_in.rd && bus_in.addr == KIR_REG_ENABLE
            |=> rdata_out[KIR_DATA_W-1:NUM_PINS] == '0)
        else $error("reserved enable bit read as one");

    // Main scenarios
    c_edge_request: cover property (rise ##1 irq_out);
    c_level_held: cover property (state == KIR_ST_PEND ##1 state == KIR_ST_HELD);
    c_ack_then_edge: cover property (sw_ack ##[1:20] rise);
    c_break_write: cover property (break_active_in && wr_status);
    c_held_release: cover property (state == KIR_ST_HELD ##1 state == KIR_ST_IDLE);

endmodule
`default_nettype wire

/* File: design/kir_pin_sync.sv */
// Two-stage synchroniser for the keypad pins.
// Assumes pins are asynchronous to clk_in; the parent keeps the
// history that compares consecutive synchronised samples.
`timescale 1ns/1ns
`default_nettype none
module kir_pin_sync
    import kir_pkg::*;
#(
    parameter int NUM_PINS = KIR_DEF_PINS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] sample_out
);

    // First stage, read only by the second stage
    logic [NUM_PINS-1:0] meta;

    // Both stages freeze with the clock enable
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta <= '0;
            sample_out <= '0;
        end else if (clk_en_in) begin
            meta <= pin_in;
            sample_out <= meta;
        end
    end

endmodule
`default_nettype wire

/* File: design/kir_pkg.sv */
// Package for the keypad interrupt unit: register map, field layout,
// reset values, latch states and the register bus carrier.
// Assumes an 8-bit register bus addressed by a small word index.
package kir_pkg;

    // Register bus geometry
    localparam int KIR_ADDR_W = 2;
    localparam int KIR_DATA_W = 8;

    // Register indices
    localparam logic [KIR_ADDR_W-1:0] KIR_REG_STATUS = 2'h0;
    localparam logic [KIR_ADDR_W-1:0] KIR_REG_ENABLE = 2'h1;
    localparam logic [KIR_ADDR_W-1:0] KIR_REG_POLARITY = 2'h2;

    // Status/control field positions
    localparam int KIR_BIT_MODE = 0;
    localparam int KIR_BIT_MASK = 1;
    localparam int KIR_BIT_ACK = 2;
    localparam int KIR_BIT_FLAG = 3;

    // Reset values
    localparam logic KIR_RST_MODE = 1'h0;
    localparam logic KIR_RST_MASK = 1'h0;
    localparam logic [KIR_DATA_W-1:0] KIR_RST_ZERO = 8'h00;

    // Pin count served by one 8-bit enable register
    localparam int KIR_DEF_PINS = 6;
    localparam int KIR_MAX_PINS = 7;

    // Shared latch states, Gray along idle -> pending -> held
    typedef enum logic [1:0] {
        KIR_ST_IDLE = 2'h0,
        KIR_ST_PEND = 2'h1,
        KIR_ST_HELD = 2'h3
    } kir_state_t;

    // One register bus request
    typedef struct packed {
        logic [KIR_ADDR_W-1:0] addr;
        logic [KIR_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } kir_bus_req_t;

endpackage
